// ==== bench/pulse_source.sv ====
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------
// pulse source on the timer lines, all lines idle low
// ---------------------------------------------------------------
module pulse_source
(
   input  wire logic aclk,           // clock
   output logic      timer_line_a,   // line A
   output logic      timer_line_b,   // line B
   output logic      ext_clock_in_0, // external input 0
   output logic      ext_clock_in_1, // external input 1
   output logic      ext_clock_in_2  // external input 2
);
   // index 0 line A, 1 line B, 2..4 external inputs 0..2
   logic [4:0] lines = 5'h00;

   assign {ext_clock_in_2, ext_clock_in_1, ext_clock_in_0, timer_line_b,
           timer_line_a} = lines;

   // w clocks high then w clocks low: both phases outlast one period
   task automatic pulse(input int ln, input int w);
      @(posedge aclk);
      lines[ln] <= 1'h1;
      repeat (w) @(posedge aclk);
      lines     <= 5'h00;
      repeat (w) @(posedge aclk);
   endtask : pulse
endmodule : pulse_source
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic        aclk = 1'h0, aresetn = 1'h0, ce = 1'h1;
   logic        timer_line_a, timer_line_b, line_a_oe, line_b_oe, irq;
   logic        ext_clock_in_0, ext_clock_in_1, ext_clock_in_2;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v, w;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
   logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   int          errors = 0, num_checks = 0;

   always #20 aclk = ~aclk;

   timer_capture_trigger timer_capture_trigger_i (.*);
   pulse_source pulse_source_i (.*);

   // ---------------------------------------------------------------
   // bus and check tasks
   // ---------------------------------------------------------------
   task automatic tally_and_finish(input logic hung);
      if (hung)
         errors++;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input string nm, input logic [31:0] e, g);
      num_checks++;
      if (g !== e)
      begin
         errors++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid  <= 1'h1;
      s_axi_bready  <= 1'h1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'h0;
      if (n == 50) tally_and_finish(1'h1);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      int n;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready  <= 1'h1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid) break;
      end
      d = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'h0;
      if (n == 50) tally_and_finish(1'h1);
   endtask : rd

   task automatic pa(input int ln);
      pulse_source_i.pulse(ln, 3);
      repeat (6) @(posedge aclk);
      rd(8'h20, v);
   endtask : pa

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_capture;
      wr(8'h00, 32'h4);
      wr(8'h04, 32'h0005_0080);
      pulse_source_i.pulse(1'h0, 3);
      pa(1'h0);
      chk("st_ab", 32'h0000_000C, v & 32'h0001_000D);
      rd(8'h14, v);
      rd(8'h18, w);
      chk("b_minus_a", 32'h7, w - v);
      pulse_source_i.pulse(1'h0, 3);
      pa(1'h0);
      chk("no_ovr", 32'h0, v & 32'h1);
      pa(1'h0);
      chk("ovr", 32'h1, v & 32'h1);
   endtask : t_capture

   task automatic t_compare;
      wr(8'h28, 32'hFFFF_FFFF);
      wr(8'h1C, 32'hA);
      wr(8'h04, 32'h4000);
      wr(8'hC0, 32'h1);
      repeat (30) @(posedge aclk);
      rd(8'h10, v);
      chk("cnt_wrap", 32'h1, 32'(v <= 32'hA));
      rd(8'h20, v);
      chk("cpc", 32'h1_0002, v & 32'h1_0002);
      wr(8'h04, 32'h0);
      repeat (30) @(posedge aclk);
      rd(8'h10, v);
      chk("cnt_free", 32'h1, 32'(v > 32'hA));
      // frozen for 20 clocks: only 3 enabled edges lie between samples
      ce <= 1'h0;
      repeat (20) @(posedge aclk);
      ce <= 1'h1;
      rd(8'h10, w);
      chk("ce_hold", 32'h3, w - v);
   endtask : t_compare

   task automatic t_wave;
      wr(8'h28, 32'hFFFF_FFFF);
      wr(8'h04, 32'h0001_8110);
      pa(2);
      chk("wave_no_en", 32'h0, v & 32'h10);
      pa(0);
      chk("wave_no_ld", 32'h0, v & 32'h4);
      wr(8'h04, 32'h0001_9110);
      pa(2);
      chk("wave_en", 32'h10, v & 32'h10);
   endtask : t_wave

   task automatic t_ext;
      wr(8'h24, 32'h10);
      for (int e = 0; e < 4; e++)
      begin
         wr(8'h28, 32'hFFFF_FFFF);
         wr(8'h04, 32'h400 | (e << 8));
         pa(1'h0);
         chk("etrg_a", (e != 0) ? 32'h10 : 32'h0, v & 32'h10);
         chk("irq", 32'(e != 0), 32'(irq));
      end
      wr(8'h28, 32'hFFFF_FFFF);
      wr(8'h04, 32'h200);
      pa(1'h0);
      chk("a_ignored", 32'h0, v & 32'h10);
      pa(1'h1);
      chk("etrg_b", 32'h10, v & 32'h10);
      chk("oe", 32'h0, {30'h0, line_a_oe, line_b_oe});
      rd(8'h80, v);
      chk("bad_rsp", 32'h2, {30'h0, rsp});
   endtask : t_ext

   initial
   begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      rd(8'h04, v);
      chk("mode_rst", 32'h0, v);
      t_capture;
      t_compare;
      t_ext;
      t_wave;
      tally_and_finish(1'h0);
   end
endmodule : tb_top
`default_nettype wire

// ==== rtl/edge_match.sv ====
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------
// selects an edge event by a two-bit edge code
// ---------------------------------------------------------------
module edge_match
(
   input  wire logic       rise, // rising edge pulse
   input  wire logic       fall, // falling edge pulse
   input  wire logic [1:0] sel,  // edge code
   output logic            hit   // selected edge seen
);
   always_comb
   begin
      unique case (tc_capture_pkg::edge_sel_t'(sel))
         tc_capture_pkg::EDGE_NONE:    hit = 1'b0;
         tc_capture_pkg::EDGE_RISING:  hit = rise;
         tc_capture_pkg::EDGE_FALLING: hit = fall;
         tc_capture_pkg::EDGE_BOTH:    hit = rise | fall;
      endcase
   end
endmodule : edge_match
`default_nettype wire

// ==== rtl/pin_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------
// two-stage synchroniser with edge detect on the settled stage
// ---------------------------------------------------------------
module pin_sync
(
   input  wire logic aclk,    // clock
   input  wire logic aresetn, // sync reset, low active
   input  wire logic ce,      // clock enable
   input  wire logic pin,     // asynchronous pin
   output logic      level,   // synchronised level
   output logic      rise,    // rising edge pulse
   output logic      fall     // falling edge pulse
);
   logic meta;
   logic sync;
   logic last;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta <= 1'b0;
         sync <= 1'b0;
         last <= 1'b0;
      end
      else if (ce)
      begin
         meta <= pin;
         sync <= meta;
         last <= sync;
      end
   end

   assign level = sync;
   assign rise  = ce & sync & ~last;
   assign fall  = ce & ~sync & last;
endmodule : pin_sync
`default_nettype wire

// ==== rtl/tc_capture_pkg.sv ====
package tc_capture_pkg;
   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] CMD_OFFS    = 8'h00; // channel_command_reg
   localparam logic [7:0] MODE_OFFS   = 8'h04; // channel_mode_reg
   localparam logic [7:0] CNT_OFFS    = 8'h10; // counter value
   localparam logic [7:0] CAPA_OFFS   = 8'h14; // capture_a
   localparam logic [7:0] CAPB_OFFS   = 8'h18; // capture_b
   localparam logic [7:0] CMPC_OFFS   = 8'h1C; // compare_c_value
   localparam logic [7:0] STAT_OFFS   = 8'h20; // channel_status_reg
   localparam logic [7:0] IEN_OFFS    = 8'h24; // interrupt enable
   localparam logic [7:0] ICLR_OFFS   = 8'h28; // status clear, write-only
   localparam logic [7:0] BLOCK_OFFS  = 8'hC0; // block_command_reg

   // ---------------------------------------------------------------
   // command bits
   // ---------------------------------------------------------------
   localparam int CMD_CLKEN_POS  = 0;
   localparam int CMD_CLKDIS_POS = 1;
   localparam int CMD_SOFT_TRIGGER_BIT_POS  = 2; // soft_trigger_bit
   localparam int BLOCK_SYNC_POS = 0;

   // ---------------------------------------------------------------
   // mode register fields
   // ---------------------------------------------------------------
   localparam int MODE_XSEL_POS   = 4;  // waveform event source, 2 bits
   localparam int MODE_CLOCK_STOP_ON_B_LOAD_POS = 7;  // clock_stop_on_b_load
   localparam int MODE_EDGE_POS   = 8;  // ext_trigger_edge, 2 bits
   localparam int MODE_ABSEL_POS  = 10; // ext_trigger_source_select
   localparam int MODE_EXT_EVENT_TRIGGER_ENABLE_POS = 12; // ext_event_trigger_enable
   localparam int MODE_COMPARE_C_TRIGGER_ENABLE_POS = 14; // compare_c_trigger_enable
   localparam int MODE_WAVE_POS   = 15;
   localparam int MODE_LDA_POS    = 16; // capture_a_edge, 2 bits
   localparam int MODE_LDB_POS    = 18; // capture_b_edge, 2 bits
   localparam logic [31:0] MODE_RESET = 32'h0000_0000;

   // ---------------------------------------------------------------
   // status bits
   // ---------------------------------------------------------------
   localparam int STAT_BITS     = 5;
   localparam int ST_OVR_POS    = 0; // load_overrun_flag
   localparam int ST_CPC_POS    = 1;
   localparam int ST_LDA_POS    = 2;
   localparam int ST_LDB_POS    = 3;
   localparam int ST_ETRG_POS   = 4;
   localparam int ST_CLKSTA_POS = 16;

   // ---------------------------------------------------------------
   // edge selection codes
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      EDGE_NONE    = 2'h0,
      EDGE_RISING  = 2'h1,
      EDGE_FALLING = 2'h2,
      EDGE_BOTH    = 2'h3
   } edge_sel_t;

   localparam logic [1:0] AXI_OKAY   = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage : tc_capture_pkg

// ==== rtl/timer_capture_trigger.sv ====
`timescale 1ns/10ps
`default_nettype none
module timer_capture_trigger
#(
   parameter int CNT_W = 16 // counter width
)
(
   input  wire logic        aclk,          // clock, 25 MHz
   input  wire logic        aresetn,       // sync reset, low active
   input  wire logic        ce,            // clock enable
   input  wire logic        timer_line_a,  // line A pin
   input  wire logic        timer_line_b,  // line B pin
   input  wire logic        ext_clock_in_0, // external input 0
   input  wire logic        ext_clock_in_1, // external input 1
   input  wire logic        ext_clock_in_2, // external input 2
   output logic             line_a_oe,     // line A drive enable
   output logic             line_b_oe,     // line B drive enable
   output logic             irq,           // interrupt level
   input  wire logic [7:0]  s_axi_awaddr,  // write address
   input  wire logic        s_axi_awvalid, // write address valid
   output logic             s_axi_awready, // write address ready
   input  wire logic [31:0] s_axi_wdata,   // write data
   input  wire logic [3:0]  s_axi_wstrb,   // write strobes
   input  wire logic        s_axi_wvalid,  // write data valid
   output logic             s_axi_wready,  // write data ready
   output logic [1:0]       s_axi_bresp,   // write response
   output logic             s_axi_bvalid,  // write response valid
   input  wire logic        s_axi_bready,  // write response ready
   input  wire logic [7:0]  s_axi_araddr,  // read address
   input  wire logic        s_axi_arvalid, // read address valid
   output logic             s_axi_arready, // read address ready
   output logic [31:0]      s_axi_rdata,   // read data
   output logic [1:0]       s_axi_rresp,   // read response
   output logic             s_axi_rvalid,  // read data valid
   input  wire logic        s_axi_rready   // read data ready
);
   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [4:0] pins;
   logic [4:0] lvl;
   logic [4:0] rise;
   logic [4:0] fall;

   assign pins = {ext_clock_in_2, ext_clock_in_1, ext_clock_in_0,
                  timer_line_b, timer_line_a};

   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++)
      begin : g_sync
         pin_sync u_sync
         (
            .aclk    (aclk),
            .aresetn (aresetn),
            .ce      (ce),
            .pin     (pins[gi]),
            .level   (lvl[gi]),
            .rise    (rise[gi]),
            .fall    (fall[gi])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [31:0]          channel_mode;
   logic [CNT_W-1:0]     counter;
   logic [CNT_W-1:0]     capture_a;
   logic [CNT_W-1:0]     capture_b;
   logic [CNT_W-1:0]     compare_c_value;
   logic                 clk_on;
   logic                 a_unread;
   logic                 b_unread;
   logic                 a_armed;  // A may load
   logic                 b_armed;  // B may load
   localparam int STAT_W = tc_capture_pkg::STAT_BITS;
   logic [STAT_W-1:0]    status;
   logic [STAT_W-1:0]    irq_en;

   logic        wave;
   logic [1:0]  edge_code;
   assign wave      = channel_mode[tc_capture_pkg::MODE_WAVE_POS];
   assign edge_code = channel_mode[tc_capture_pkg::MODE_EDGE_POS +: 2];

   // both lines are inputs in capture mode; waveform driving is not
   // part of this block, so the lines stay undriven
   assign line_a_oe = 1'b0;
   assign line_b_oe = 1'b0;

   // ---------------------------------------------------------------
   // bus slave
   // ---------------------------------------------------------------
   logic [7:0]  waddr;
   logic [31:0] wdata;
   logic        have_aw;
   logic        have_w;
   logic        wstrb0;
   logic        wr_fire;
   logic        rd_fire;

   // no item is taken while frozen, so ready stays low then
   assign s_axi_awready = ce & ~have_aw & ~s_axi_bvalid;
   assign s_axi_wready  = ce & ~have_w & ~s_axi_bvalid;
   assign s_axi_arready = ce & ~s_axi_rvalid;
   assign wr_fire = ce & have_aw & have_w & ~s_axi_bvalid;
   assign rd_fire = ce & s_axi_arvalid & s_axi_arready;

   function automatic logic mapped(input logic [7:0] a);
      unique case (a)
         tc_capture_pkg::CMD_OFFS, tc_capture_pkg::MODE_OFFS,
         tc_capture_pkg::CNT_OFFS, tc_capture_pkg::CAPA_OFFS,
         tc_capture_pkg::CAPB_OFFS, tc_capture_pkg::CMPC_OFFS,
         tc_capture_pkg::STAT_OFFS, tc_capture_pkg::IEN_OFFS,
         tc_capture_pkg::ICLR_OFFS, tc_capture_pkg::BLOCK_OFFS:
            mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   endfunction : mapped

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         have_aw      <= 1'b0;
         have_w       <= 1'b0;
         waddr        <= 8'h00;
         wdata        <= 32'h0000_0000;
         wstrb0       <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= tc_capture_pkg::AXI_OKAY;
      end
      else if (ce)
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            have_aw <= 1'b1;
            waddr   <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            have_w <= 1'b1;
            wdata  <= s_axi_wdata;
            wstrb0 <= s_axi_wstrb[0];
         end
         if (wr_fire)
         begin
            have_aw      <= 1'b0;
            have_w       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(waddr) ? tc_capture_pkg::AXI_OKAY
                                          : tc_capture_pkg::AXI_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // whole-word writes only need lane 0 for the command bits
   logic wr_cmd;
   logic wr_blk;
   assign wr_cmd = wr_fire & (waddr == tc_capture_pkg::CMD_OFFS) & wstrb0;
   assign wr_blk = wr_fire & (waddr == tc_capture_pkg::BLOCK_OFFS) & wstrb0;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         channel_mode    <= tc_capture_pkg::MODE_RESET;
         compare_c_value <= '0;
         irq_en          <= '0;
      end
      else if (wr_fire)
      begin
         if (waddr == tc_capture_pkg::MODE_OFFS)
            channel_mode <= wdata;
         if (waddr == tc_capture_pkg::CMPC_OFFS)
            compare_c_value <= wdata[CNT_W-1:0];
         if (waddr == tc_capture_pkg::IEN_OFFS)
            irq_en <= wdata[STAT_W-1:0];
      end
   end

   // ---------------------------------------------------------------
   // triggers
   // ---------------------------------------------------------------
   logic sw_trig;
   logic sync_trig;
   logic cmp_match;
   logic cmp_trig;
   logic ext_rise;
   logic ext_fall;
   logic ext_hit;
   logic ext_trig;
   logic trigger;
   logic [1:0] xsel;

   assign sw_trig   = wr_cmd
                    & wdata[tc_capture_pkg::CMD_SOFT_TRIGGER_BIT_POS];
   assign sync_trig = wr_blk
                    & wdata[tc_capture_pkg::BLOCK_SYNC_POS];
   assign cmp_match = ce & clk_on & (counter == compare_c_value);
   assign cmp_trig  = cmp_match
                    & channel_mode[tc_capture_pkg::MODE_COMPARE_C_TRIGGER_ENABLE_POS];
   assign xsel      = channel_mode[tc_capture_pkg::MODE_XSEL_POS +: 2];

   always_comb
   begin
      if (!wave)
      begin
         // capture mode source select
         ext_rise = channel_mode[tc_capture_pkg::MODE_ABSEL_POS]
                  ? rise[0] : rise[1];
         ext_fall = channel_mode[tc_capture_pkg::MODE_ABSEL_POS]
                  ? fall[0] : fall[1];
      end
      else
      begin
         // waveform event: 0 line B, 1..3 external inputs
         ext_rise = (xsel == 2'h0) ? rise[1]
                  : rise[3'(xsel) + 3'h1];
         ext_fall = (xsel == 2'h0) ? fall[1]
                  : fall[3'(xsel) + 3'h1];
      end
   end

   edge_match u_ext_edge
   (
      .rise (ext_rise),
      .fall (ext_fall),
      .sel  (edge_code),
      .hit  (ext_hit)
   );

   assign ext_trig = ext_hit & (!wave
                   | channel_mode[tc_capture_pkg::MODE_EXT_EVENT_TRIGGER_ENABLE_POS]);
   assign trigger  = sw_trig | sync_trig | cmp_trig | ext_trig;

   // ---------------------------------------------------------------
   // capture loads on line A edges
   // ---------------------------------------------------------------
   logic hit_a;
   logic hit_b;
   logic load_a;
   logic load_b;

   edge_match u_lda
   (
      .rise (rise[0]),
      .fall (fall[0]),
      .sel  (channel_mode[tc_capture_pkg::MODE_LDA_POS +: 2]),
      .hit  (hit_a)
   );

   edge_match u_ldb
   (
      .rise (rise[0]),
      .fall (fall[0]),
      .sel  (channel_mode[tc_capture_pkg::MODE_LDB_POS +: 2]),
      .hit  (hit_b)
   );

   assign load_a = ~wave & hit_a & a_armed;
   assign load_b = ~wave & hit_b & b_armed & ~load_a;

   logic rd_a;
   logic rd_b;
   logic [7:0] raddr;
   assign raddr = {s_axi_araddr[7:2], 2'b00};
   assign rd_a  = rd_fire & (raddr == tc_capture_pkg::CAPA_OFFS);
   assign rd_b  = rd_fire & (raddr == tc_capture_pkg::CAPB_OFFS);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         capture_a <= '0;
         capture_b <= '0;
         a_armed   <= 1'b1;
         b_armed   <= 1'b0;
         a_unread  <= 1'b0;
         b_unread  <= 1'b0;
      end
      else if (ce)
      begin
         if (trigger)
         begin
            a_armed <= 1'b1;
            b_armed <= 1'b0;
         end
         else if (load_a)
         begin
            a_armed <= 1'b0;
            b_armed <= 1'b1;
         end
         else if (load_b)
         begin
            a_armed <= 1'b1;
            b_armed <= 1'b0;
         end
         if (load_a)
            capture_a <= counter;
         if (load_b)
            capture_b <= counter;
         // a load in the read cycle wins: new value stays unread
         a_unread <= load_a | (a_unread & ~rd_a);
         b_unread <= load_b | (b_unread & ~rd_b);
      end
   end

   // ---------------------------------------------------------------
   // counter and its clock
   // ---------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         counter <= '0;
         clk_on  <= 1'b0;
      end
      else if (ce)
      begin
         if (wr_cmd && wdata[tc_capture_pkg::CMD_CLKDIS_POS])
            clk_on <= 1'b0;
         else if (load_b && channel_mode[tc_capture_pkg::MODE_CLOCK_STOP_ON_B_LOAD_POS])
            clk_on <= 1'b0;
         else if (trigger || (wr_cmd && wdata[tc_capture_pkg::CMD_CLKEN_POS]))
            clk_on <= 1'b1;
         if (trigger)
            counter <= '0;
         else if (clk_on)
            counter <= counter + 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // status, interrupt and read data
   // ---------------------------------------------------------------
   logic [STAT_W-1:0] events;
   logic [STAT_W-1:0] clr;
   assign events = {ext_trig, load_b, load_a, cmp_match,
                    (load_a & a_unread) | (load_b & b_unread)};
   assign clr = (wr_fire && waddr == tc_capture_pkg::ICLR_OFFS)
              ? wdata[STAT_W-1:0] : '0;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         status <= '0;
      else if (ce)
         status <= events | (status & ~clr);
   end

   assign irq = |(status & irq_en);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= tc_capture_pkg::AXI_OKAY;
      end
      else if (ce)
      begin
         if (rd_fire)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= mapped({s_axi_araddr[7:2], 2'b00})
                          ? tc_capture_pkg::AXI_OKAY
                          : tc_capture_pkg::AXI_SLVERR;
            unique case ({s_axi_araddr[7:2], 2'b00})
               tc_capture_pkg::MODE_OFFS: s_axi_rdata <= channel_mode;
               tc_capture_pkg::CNT_OFFS:  s_axi_rdata <= 32'(counter);
               tc_capture_pkg::CAPA_OFFS: s_axi_rdata <= 32'(capture_a);
               tc_capture_pkg::CAPB_OFFS: s_axi_rdata <= 32'(capture_b);
               tc_capture_pkg::CMPC_OFFS: s_axi_rdata <= 32'(compare_c_value);
               tc_capture_pkg::STAT_OFFS: s_axi_rdata <= 32'(status)
                  | (32'(clk_on) << tc_capture_pkg::ST_CLKSTA_POS)
                  | (32'(lvl[0]) << 17) | (32'(lvl[1]) << 18);
               tc_capture_pkg::IEN_OFFS:  s_axi_rdata <= 32'(irq_en);
               default:                   s_axi_rdata <= 32'h0000_0000;
            endcase
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   // record of an A load since the last trigger or B load, kept apart
   // from the arming flags so the order check does not reuse them
   logic a_seen;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         a_seen <= 1'b0;
      else if (ce)
      begin
         if (trigger || load_b)
            a_seen <= 1'b0;
         if (load_a)
            a_seen <= 1'b1;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sw_trig_clear_a: assert property (sw_trig |=> counter == '0)
      else $error("software trigger did not clear counter");
   sync_trig_a: assert property
      (sync_trig |=> counter == '0 && clk_on)
      else $error("sync write did not trigger");
   cmp_off_a: assert property
      (cmp_match && !channel_mode[tc_capture_pkg::MODE_COMPARE_C_TRIGGER_ENABLE_POS]
      && !sw_trig && !sync_trig && !ext_trig
      |=> counter == $past(counter) + 1'b1)
      else $error("disabled compare match reset counter");
   cmp_start_a: assert property (cmp_trig && !load_b |=> clk_on)
      else $error("compare trigger did not start clock");
   order_ab_a: assert property (load_b |-> a_seen)
      else $error("capture b loaded before a");
   no_double_a: assert property
      (ce && load_a |=> !a_armed || $past(trigger))
      else $error("capture a rearmed without b");
   overrun_set_a: assert property
      (load_a && a_unread |=> status[tc_capture_pkg::ST_OVR_POS])
      else $error("overrun flag not set");
   ldb_stop_a: assert property
      (load_b && channel_mode[tc_capture_pkg::MODE_CLOCK_STOP_ON_B_LOAD_POS]
      && !trigger |=> !clk_on)
      else $error("clock kept running after b load");
   consume_a: assert property (ce && rd_a && !load_a |=> !a_unread)
      else $error("read did not consume capture a");
   wave_no_load_a: assert property (wave |-> !load_a && !load_b)
      else $error("capture in waveform mode");

   ab_seq_c: cover property (load_a ##[1:50] load_b);
   overrun_c: cover property (ce && load_a && a_unread);
   ext_trig_c: cover property (ext_trig);
   irq_c: cover property (irq);
endmodule : timer_capture_trigger
`default_nettype wire
